// [logic/dual_timer_with_interrupt_logic.v]
// Two prescaled down-counters with three-source vectored interrupt logic
`timescale 1ns/1ps
`default_nettype none
`include "dual_timer_defines.vh"

module timer_channel #(
    parameter CW = 8,
    parameter PW = 6
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Control
    input wire tick,
    input wire run,
    input wire restart,
    input wire cont,
    input wire [CW-1:0] reload,
    input wire [PW-1:0] div,
    // Status
    output wire [CW-1:0] count,
    output wire active,
    output reg eoc_r,
    output reg toggle_r
);
    reg [CW-1:0] count_r;
    reg [PW-1:0] pre_r;
    reg done_r;
    wire pre_wrap;
    wire step;

    // Divide value zero means divide by 64
    assign pre_wrap = (pre_r == {PW{1'b0}});
    assign active = run && !done_r;
    assign step = active && tick && pre_wrap;
    assign count = count_r;

    always @(posedge clk) begin
        if (rst) begin
            count_r <= {CW{1'b0}};
            pre_r <= {PW{1'b0}};
            done_r <= 1'b1;
            eoc_r <= 1'b0;
            toggle_r <= 1'b0;
        end else begin
            eoc_r <= 1'b0;
            if (restart) begin
                count_r <= reload;
                pre_r <= div - {{(PW-1){1'b0}}, 1'b1};
                done_r <= 1'b0;
            end else begin
                if (active && tick) begin
                    if (pre_wrap) begin
                        pre_r <= div - {{(PW-1){1'b0}}, 1'b1};
                    end else begin
                        pre_r <= pre_r - {{(PW-1){1'b0}}, 1'b1};
                    end
                end
                if (step) begin
                    // Load of zero runs the full 256 steps
                    if (count_r == {{(CW-1){1'b0}}, 1'b1}) begin
                        eoc_r <= 1'b1;
                        toggle_r <= !toggle_r;
                        if (cont) begin
                            count_r <= reload;
                        end else begin
                            count_r <= {CW{1'b0}};
                            done_r <= 1'b1;
                        end
                    end else begin
                        count_r <= count_r - {{(CW-1){1'b0}}, 1'b1};
                    end
                end
            end
        end
    end
endmodule // timer_channel

module dual_timer_with_interrupt_logic #(
    parameter CW = 8,
    parameter PW = 6
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Register port
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    output reg [7:0] rdata_r,
    // Interrupt handshake with the core
    output wire int_request,
    input wire int_ack,
    output reg int_cycle_r,
    output reg [15:0] int_vector_r,
    // Port lines
    input wire external_request_port_line,
    input wire timer_port_line_in,
    output reg timer_port_line_out_r,
    output reg timer_port_line_oe_n_r
);
    reg [7:0] ctrl_r;
    reg [CW-1:0] t0_reload_r;
    reg [CW-1:0] t1_reload_r;
    reg [7:0] t0_pre_r;
    reg [7:0] t1_pre_r;
    reg [7:0] cfg_r;
    reg [2:0] pend_r;
    reg [2:0] pend_nxt;
    reg [7:0] mask_r;
    reg [2:0] prio_r;
    reg [1:0] int_div_r;
    reg pin_meta_r;
    reg pin_sync_r;
    reg pin_prev_r;
    reg req_prev_r;
    reg [1:0] winner;
    reg have_winner;
    reg [7:0] rdata_nxt;
    integer k;
    integer cand;

    wire [CW-1:0] t0_count;
    wire [CW-1:0] t1_count;
    wire t0_active;
    wire t1_active;
    wire t0_eoc;
    wire t1_eoc;
    wire t0_toggle;
    wire t1_toggle;
    wire int_tick;
    wire pin_rise;
    wire pin_fall;
    wire [1:0] pin_use;
    wire [1:0] out_sel;
    wire t1_ext;
    wire trig_mode;
    wire trigger;
    wire t0_restart;
    wire t1_restart;
    wire t1_tick;
    wire req_fall;
    wire [2:0] pend_masked;
    wire grant;
    wire wr_ctrl;

    // The first timer, and the second unless cascaded or clocked by the pin, run from the processor clock divided by four
    assign int_tick = (int_div_r == `INT_DIV_LAST);
    assign pin_use = ctrl_r[`CTRL_PIN_HI:`CTRL_PIN_LO];
    assign out_sel = ctrl_r[`CTRL_OUT_HI:`CTRL_OUT_LO];
    assign t1_ext = t1_pre_r[`PRE_SRC];
    assign pin_rise = pin_sync_r && !pin_prev_r;
    assign pin_fall = !pin_sync_r && pin_prev_r;
    assign trig_mode = (pin_use == `PIN_TRIG_ONCE) ||
                       (pin_use == `PIN_TRIG_RE);
    // A one-shot trigger is ignored while the second timer is counting
    assign trigger = t1_ext && trig_mode && pin_fall &&
                     ((pin_use == `PIN_TRIG_RE) || !t1_active);
    assign wr_ctrl = wr && (addr == `ADDR_CTRL);
    assign t0_restart = wr_ctrl && wdata[`CTRL_T0_LOAD];
    assign t1_restart = (wr_ctrl && wdata[`CTRL_T1_LOAD]) || trigger;

    // Cascade takes precedence over the pin as clock source
    assign t1_tick = cfg_r[`CFG_CASCADE] ? t0_eoc :
                     !t1_ext ? int_tick :
                     (pin_use == `PIN_EXT_CLK) ? pin_rise :
                     (pin_use == `PIN_GATE) ? (int_tick && pin_sync_r) :
                     int_tick;

    // Request line is used directly; it is already synchronous
    assign req_fall = !external_request_port_line && req_prev_r;
    assign pend_masked = pend_r & mask_r[2:0];
    assign int_request = mask_r[`MASK_GLOBAL] && have_winner;
    assign grant = int_request && int_ack;

    timer_channel #(.CW(CW), .PW(PW)) u_first_timer (
        .clk(clk),
        .rst(rst),
        .tick(int_tick),
        .run(ctrl_r[`CTRL_T0_RUN]),
        .restart(t0_restart),
        .cont(t0_pre_r[`PRE_CONT]),
        .reload(t0_reload_r),
        .div(t0_pre_r[`PRE_DIV_HI:`PRE_DIV_LO]),
        .count(t0_count),
        .active(t0_active),
        .eoc_r(t0_eoc),
        .toggle_r(t0_toggle)
    );

    timer_channel #(.CW(CW), .PW(PW)) u_second_timer (
        .clk(clk),
        .rst(rst),
        .tick(t1_tick),
        .run(ctrl_r[`CTRL_T1_RUN]),
        .restart(t1_restart),
        .cont(t1_pre_r[`PRE_CONT]),
        .reload(t1_reload_r),
        .div(t1_pre_r[`PRE_DIV_HI:`PRE_DIV_LO]),
        .count(t1_count),
        .active(t1_active),
        .eoc_r(t1_eoc),
        .toggle_r(t1_toggle)
    );

    // Rotating order from a start source, in either direction; start value 3 gives the fixed order 0, 1, 2
    always @* begin
        winner = 2'h0;
        have_winner = 1'b0;
        cand = 0;
        for (k = 2; k >= 0; k = k - 1) begin
            if (prio_r[`PRIO_DIR]) begin
                cand = (prio_r[1:0] + 3 - k) % 3;
            end else begin
                cand = (prio_r[1:0] + k) % 3;
            end
            if (prio_r[1:0] == 2'h3) begin
                cand = k;
            end
            if (pend_masked[cand]) begin
                winner = cand[1:0];
                have_winner = 1'b1;
            end
        end
    end

    // Hardware set wins over software or acknowledge clear
    always @* begin
        pend_nxt = pend_r;
        if (wr && (addr == `ADDR_IRQ)) begin
            pend_nxt = pend_nxt & ~wdata[2:0];
        end
        if (grant) begin
            pend_nxt[winner] = 1'b0;
        end
        if (req_fall && cfg_r[`CFG_EXT_IRQ]) begin
            pend_nxt[`SRC_EXT] = 1'b1;
        end
        if (t0_eoc) begin
            pend_nxt[`SRC_T0] = 1'b1;
        end
        if (t1_eoc) begin
            pend_nxt[`SRC_T1] = 1'b1;
        end
    end

    always @* begin
        rdata_nxt = `RST_BYTE;
        if (addr == `ADDR_CTRL) begin
            rdata_nxt = {ctrl_r[7:4], ctrl_r[`CTRL_T1_RUN], 1'b0,
                         ctrl_r[`CTRL_T0_RUN], 1'b0};
        end else if (addr == `ADDR_T0_RELOAD) begin
            rdata_nxt = t0_count;
        end else if (addr == `ADDR_T0_PRE) begin
            rdata_nxt = {6'h00, t0_pre_r[`PRE_CONT], 1'b0};
        end else if (addr == `ADDR_T1_RELOAD) begin
            rdata_nxt = t1_count;
        end else if (addr == `ADDR_T1_PRE) begin
            rdata_nxt = {6'h00, t1_pre_r[`PRE_CONT], t1_ext};
        end else if (addr == `ADDR_CFG) begin
            rdata_nxt = {5'h00, cfg_r[2:0]};
        end else if (addr == `ADDR_IRQ) begin
            rdata_nxt = {external_request_port_line, 4'h0, pend_r};
        end else if (addr == `ADDR_MASK) begin
            rdata_nxt = {mask_r[`MASK_GLOBAL], 4'h0, mask_r[2:0]};
        end else if (addr == `ADDR_PRIO) begin
            rdata_nxt = {5'h00, prio_r};
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            ctrl_r <= `RST_BYTE;
            t0_reload_r <= {CW{1'b0}};
            t1_reload_r <= {CW{1'b0}};
            t0_pre_r <= `RST_BYTE;
            t1_pre_r <= `RST_BYTE;
            cfg_r <= `RST_BYTE;
            pend_r <= 3'h0;
            mask_r <= `RST_BYTE;
            prio_r <= `RST_PRIO;
            int_div_r <= 2'h0;
            pin_meta_r <= 1'b0;
            pin_sync_r <= 1'b0;
            pin_prev_r <= 1'b0;
            req_prev_r <= 1'b1;
            rdata_r <= `RST_BYTE;
            int_cycle_r <= 1'b0;
            int_vector_r <= 16'h0000;
            timer_port_line_out_r <= 1'b0;
            timer_port_line_oe_n_r <= 1'b1;
        end else begin
            int_div_r <= int_div_r + 2'h1;
            pin_meta_r <= timer_port_line_in;
            pin_sync_r <= pin_meta_r;
            pin_prev_r <= pin_sync_r;
            req_prev_r <= external_request_port_line;
            pend_r <= pend_nxt;
            rdata_r <= rd ? rdata_nxt : `RST_BYTE;
            int_cycle_r <= grant;
            if (wr) begin
                if (addr == `ADDR_CTRL) begin
                    // Load bits are strobes and are not stored
                    ctrl_r <= {wdata[7:4], wdata[`CTRL_T1_RUN], 1'b0,
                               wdata[`CTRL_T0_RUN], 1'b0};
                end else if (addr == `ADDR_T0_RELOAD) begin
                    t0_reload_r <= wdata[CW-1:0];
                end else if (addr == `ADDR_T0_PRE) begin
                    // First timer has no source select
                    t0_pre_r <= {wdata[7:1], 1'b0};
                end else if (addr == `ADDR_T1_RELOAD) begin
                    t1_reload_r <= wdata[CW-1:0];
                end else if (addr == `ADDR_T1_PRE) begin
                    t1_pre_r <= wdata;
                end else if (addr == `ADDR_CFG) begin
                    cfg_r <= {5'h00, wdata[2:0]};
                end else if (addr == `ADDR_MASK) begin
                    mask_r <= {wdata[`MASK_GLOBAL], 4'h0, wdata[2:0]};
                end else if (addr == `ADDR_PRIO) begin
                    prio_r <= wdata[2:0];
                end
            end
            if (grant) begin
                // Core saves PC and flags; further grants wait for enable
                mask_r[`MASK_GLOBAL] <= 1'b0;
                case (winner)
                    `SRC_EXT: begin
                        int_vector_r <= `VEC_EXT;
                    end
                    `SRC_T0: begin
                        int_vector_r <= `VEC_T0;
                    end
                    default: begin
                        int_vector_r <= `VEC_T1;
                    end
                endcase
            end
            // Pin is released whenever it serves as the timer input
            timer_port_line_oe_n_r <= t1_ext;
            case (out_sel)
                `OUT_T0: begin
                    timer_port_line_out_r <= t0_toggle;
                end
                `OUT_T1: begin
                    timer_port_line_out_r <= t1_toggle;
                end
                `OUT_CLK: begin
                    timer_port_line_out_r <= int_div_r[1];
                end
                default: begin
                    timer_port_line_out_r <= cfg_r[`CFG_GPO];
                end
            endcase
        end
    end
endmodule // dual_timer_with_interrupt_logic
`default_nettype wire

// [logic/dual_timer_defines.vh]
// Constants for the dual timer and interrupt block
`ifndef DUAL_TIMER_DEFINES_VH
`define DUAL_TIMER_DEFINES_VH

// Register addresses
`define ADDR_CTRL       8'h00
`define ADDR_T0_RELOAD  8'h01
`define ADDR_T0_PRE     8'h02
`define ADDR_T1_RELOAD  8'h03
`define ADDR_T1_PRE     8'h04
`define ADDR_CFG        8'h05
`define ADDR_IRQ        8'h06
`define ADDR_MASK       8'h07
`define ADDR_PRIO       8'h08

// Control register fields
`define CTRL_T0_LOAD    0
`define CTRL_T0_RUN     1
`define CTRL_T1_LOAD    2
`define CTRL_T1_RUN     3
`define CTRL_PIN_LO     4
`define CTRL_PIN_HI     5
`define CTRL_OUT_LO     6
`define CTRL_OUT_HI     7

// Prescaler register fields
`define PRE_SRC         0
`define PRE_CONT        1
`define PRE_DIV_LO      2
`define PRE_DIV_HI      7

// Configuration register fields
`define CFG_CASCADE     0
`define CFG_EXT_IRQ     1
`define CFG_GPO         2

// Interrupt source, global mask, request input and priority direction bits
`define SRC_EXT         0
`define SRC_T0          1
`define SRC_T1          2
`define MASK_GLOBAL     7
`define IRQ_IN_BIT      7
`define PRIO_DIR        2

// Timer input uses
`define PIN_EXT_CLK     2'h0
`define PIN_GATE        2'h1
`define PIN_TRIG_ONCE   2'h2
`define PIN_TRIG_RE     2'h3

// Timer output choices
`define OUT_GPO         2'h0
`define OUT_T0          2'h1
`define OUT_T1          2'h2
`define OUT_CLK         2'h3

// Vector locations, two bytes each, inside the first twelve bytes
`define VEC_EXT         16'h0004
`define VEC_T0          16'h0008
`define VEC_T1          16'h000A

// Reset values and the last prescaler divider count
`define RST_BYTE        8'h00
`define RST_PRIO        3'h0
`define INT_DIV_LAST    2'h3

`endif

// [sim/dual_timer_assertions.sv]
// Port assertions for the dual timer and interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "dual_timer_defines.vh"
module dual_timer_checker #(
    parameter CW = 8,
    parameter PW = 6
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata_r,
    // Interrupt handshake
    input wire logic int_request,
    input wire logic int_ack,
    input wire logic int_cycle_r,
    input wire logic [15:0] int_vector_r,
    // Port lines
    input wire logic external_request_port_line,
    input wire logic timer_port_line_in,
    input wire logic timer_port_line_out_r,
    input wire logic timer_port_line_oe_n_r
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    ack_grant_a:
        assert property (int_ack && int_request |=> int_cycle_r)
        else $error("ack not granted");
    ack_refused_a:
        assert property (int_ack && !int_request |=> !int_cycle_r)
        else $error("grant without request");
    grant_quiet_a:
        assert property (int_cycle_r |-> !int_request ##1 !int_cycle_r)
        else $error("interrupts not disabled by grant");
    grant_cause_a:
        assert property ($rose(int_cycle_r) |-> $past(int_ack))
        else $error("grant without ack");
    vector_legal_a:
        assert property (int_cycle_r |->
            int_vector_r inside {`VEC_EXT, `VEC_T0, `VEC_T1})
        else $error("vector outside table");
    vector_hold_a:
        assert property (!int_cycle_r && !$past(rst)
            |-> $stable(int_vector_r))
        else $error("vector moved without grant");
    mask_global_a:
        assert property (wr && addr == `ADDR_MASK && !wdata[`MASK_GLOBAL]
            |=> !int_request)
        else $error("request with global enable off");
    mask_each_a:
        assert property (wr && addr == `ADDR_MASK && wdata[2:0] == 3'h0
            |=> !int_request)
        else $error("request with all sources masked");
    pre_hidden_a:
        assert property (rd && (addr == `ADDR_T0_PRE || addr == `ADDR_T1_PRE)
            |=> rdata_r[7:2] == 6'h00)
        else $error("prescaler ratio readable");
endmodule // dual_timer_checker
bind dual_timer_with_interrupt_logic dual_timer_checker #(
    .CW(CW),
    .PW(PW)
) checker_i (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_r(rdata_r), .int_request(int_request), .int_ack(int_ack),
    .int_cycle_r(int_cycle_r), .int_vector_r(int_vector_r),
    .external_request_port_line(external_request_port_line),
    .timer_port_line_in(timer_port_line_in),
    .timer_port_line_out_r(timer_port_line_out_r),
    .timer_port_line_oe_n_r(timer_port_line_oe_n_r)
);
`default_nettype wire

// [sim/pin_partner.sv]
// Far-side model: timer pin source and external request line
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
    // Clock
    input wire logic clk,
    // Timer pin as the block drives it
    input wire logic pin_out,
    input wire logic pin_oe_n,
    // Levels the block sees
    output logic pin_in,
    output logic req_line
);
    logic drive_r;
    logic level_r;
    logic float_r;
    initial begin
        drive_r = 1'b0;
        level_r = 1'b0;
        float_r = 1'b0;
        req_line = 1'b1;
    end
    // A released pin wanders, so a stale level is never trusted
    always @(posedge clk) float_r <= ~float_r;
    assign pin_in = !pin_oe_n ? pin_out : (drive_r ? level_r : float_r);
    task automatic hold_low;
        @(posedge clk);
        drive_r <= 1'b1;
        level_r <= 1'b0;
    endtask
    // Levels last hold clocks, 2 to 6 here, against an internal tick every 4 clocks
    task automatic pulses(input int n, input int hold);
        repeat (n) begin
            repeat (hold) @(posedge clk);
            level_r <= 1'b1;
            repeat (hold) @(posedge clk);
            level_r <= 1'b0;
        end
    endtask
    task automatic request(input logic lvl);
        @(posedge clk);
        req_line <= lvl;
    endtask
endmodule // pin_partner
`default_nettype wire

// [sim/tb_top.sv]
// Self-checking bench for the dual timer and interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "dual_timer_defines.vh"
module tb_top;
    logic clk, rst, wr, rd, int_ack;
    logic [7:0] addr, wdata, v, w;
    logic [15:0] vec;
    wire logic int_request, int_cycle_r, pin_in, pin_out, pin_oe_n, req_line;
    wire logic [7:0] rdata_r;
    wire logic [15:0] int_vector_r;
    int n_errors, n_compared, cyc;

    dual_timer_with_interrupt_logic #(
        .CW(8),
        .PW(6)
    ) dual_timer_with_interrupt_logic_i (
        .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata_r(rdata_r), .int_request(int_request), .int_ack(int_ack),
        .int_cycle_r(int_cycle_r), .int_vector_r(int_vector_r),
        .external_request_port_line(req_line), .timer_port_line_in(pin_in),
        .timer_port_line_out_r(pin_out), .timer_port_line_oe_n_r(pin_oe_n)
    );
    pin_partner pin_partner_i (
        .clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_in(pin_in),
        .req_line(req_line)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            $display("unexpected at %0t: run did not finish", $time);
            end_of_test();
        end
    end

    task automatic end_of_test;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input logic ok, input string what);
        n_compared++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata_r;
    endtask
    task automatic rd_chk(input logic [7:0] a, e, m);
        logic [7:0] d;
        rd_reg(a, d);
        check((d & m) === e, $sformatf("register %h read %h", a, d));
    endtask
    task automatic ack(input logic ex, output logic [15:0] vg);
        @(posedge clk);
        int_ack <= 1'b1;
        @(posedge clk);
        int_ack <= 1'b0;
        #1;
        check(int_cycle_r === ex && int_request === 1'b0, "grant");
        vg = int_vector_r;
    endtask
    task automatic do_reset;
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
    endtask

    task automatic t_single;
        do_reset();
        wr_reg(`ADDR_T0_RELOAD, 8'h03);
        wr_reg(`ADDR_T0_PRE, 8'h04);
        wr_reg(`ADDR_CTRL, 8'h03);
        repeat (40) @(posedge clk);
        rd_chk(`ADDR_T0_RELOAD, 8'h00, 8'hFF);
        rd_chk(`ADDR_T0_PRE, 8'h00, 8'hFC);
        rd_chk(`ADDR_IRQ, 8'h02, 8'h07);
        wr_reg(`ADDR_MASK, 8'h02);
        #1;
        check(int_request === 1'b0, "global enable ignored");
        wr_reg(`ADDR_MASK, 8'h80);
        #1;
        check(int_request === 1'b0, "all masked yet requests");
        wr_reg(`ADDR_MASK, 8'h84);
        #1;
        check(int_request === 1'b0, "masked source requests");
        wr_reg(`ADDR_MASK, 8'h82);
        #1;
        check(int_request === 1'b1, "enabled source silent");
        ack(1'b1, vec);
        check(vec === `VEC_T0, "first timer vector");
        rd_chk(`ADDR_IRQ, 8'h00, 8'h07);
    endtask
    task automatic t_prio;
        logic [7:0] pr [4];
        logic [15:0] ve [4];
        pr = '{8'h03, 8'h02, 8'h04, 8'h00};
        ve = '{`VEC_T0, `VEC_T1, `VEC_T1, `VEC_T0};
        do_reset();
        wr_reg(`ADDR_T0_RELOAD, 8'h01);
        wr_reg(`ADDR_T1_RELOAD, 8'h01);
        wr_reg(`ADDR_T0_PRE, 8'h04);
        wr_reg(`ADDR_T1_PRE, 8'h04);
        for (int i = 0; i < 4; i++) begin
            wr_reg(`ADDR_CTRL, 8'h0F);
            repeat (30) @(posedge clk);
            rd_chk(`ADDR_IRQ, 8'h06, 8'h07);
            wr_reg(`ADDR_PRIO, pr[i]);
            wr_reg(`ADDR_MASK, 8'h86);
            ack(1'b1, vec);
            check(vec === ve[i], "priority winner");
        end
    endtask
    task automatic t_cont;
        do_reset();
        wr_reg(`ADDR_T0_RELOAD, 8'h02);
        wr_reg(`ADDR_T0_PRE, 8'h06);
        wr_reg(`ADDR_CTRL, 8'h03);
        repeat (40) @(posedge clk);
        wr_reg(`ADDR_IRQ, 8'h02);
        repeat (20) @(posedge clk);
        rd_chk(`ADDR_IRQ, 8'h02, 8'h07);
        rd_reg(`ADDR_T0_RELOAD, v);
        check(v === 8'h01 || v === 8'h02, "continuous count");
    endtask
    task automatic t_stop;
        do_reset();
        wr_reg(`ADDR_T0_RELOAD, 8'h00);
        wr_reg(`ADDR_T0_PRE, 8'h00);
        wr_reg(`ADDR_CTRL, 8'h03);
        repeat (200) @(posedge clk);
        rd_chk(`ADDR_T0_RELOAD, 8'h00, 8'hFF);
        repeat (120) @(posedge clk);
        rd_chk(`ADDR_T0_RELOAD, 8'hFF, 8'hFF);
        wr_reg(`ADDR_T0_PRE, 8'h04);
        wr_reg(`ADDR_CTRL, 8'h03);
        repeat (20) @(posedge clk);
        wr_reg(`ADDR_CTRL, 8'h00);
        rd_reg(`ADDR_T0_RELOAD, v);
        check(v > 8'hF0 && v < 8'hFF, "count from 256");
        repeat (20) @(posedge clk);
        rd_chk(`ADDR_T0_RELOAD, v, 8'hFF);
        wr_reg(`ADDR_CTRL, 8'h02);
        repeat (20) @(posedge clk);
        rd_reg(`ADDR_T0_RELOAD, w);
        check(w < v && w > 8'hE0, "resume");
        wr_reg(`ADDR_CTRL, 8'h03);
        rd_reg(`ADDR_T0_RELOAD, w);
        check(w === 8'h00 || w === 8'hFF, "restart");
    endtask
    task automatic t_ext;
        do_reset();
        wr_reg(`ADDR_T1_RELOAD, 8'h0A);
        wr_reg(`ADDR_T1_PRE, 8'h05);
        pin_partner_i.hold_low();
        repeat (4) @(posedge clk);
        wr_reg(`ADDR_CTRL, 8'h0C);
        #1;
        check(pin_oe_n === 1'b1, "pin not released");
        pin_partner_i.pulses(2, 3);
        pin_partner_i.pulses(2, 6);
        repeat (6) @(posedge clk);
        rd_chk(`ADDR_T1_RELOAD, 8'h06, 8'hFF);
        // Retriggerable: a falling edge reloads while still counting
        wr_reg(`ADDR_CTRL, 8'h38);
        pin_partner_i.pulses(1, 2);
        repeat (6) @(posedge clk);
        rd_reg(`ADDR_T1_RELOAD, v);
        check(v >= 8'h08 && v <= 8'h0A, "retrigger");
    endtask
    task automatic t_pin;
        int n;
        n = 0;
        do_reset();
        wr_reg(`ADDR_CFG, 8'h04);
        repeat (2) @(posedge clk);
        check(pin_out === 1'b1 && pin_oe_n === 1'b0, "gpo");
        wr_reg(`ADDR_CTRL, 8'hC0);
        repeat (16) begin
            v[0] = pin_out;
            @(posedge clk);
            #1;
            n += (pin_out !== v[0]);
        end
        check(n >= 6 && n <= 9, "clock out");
        for (int i = 0; i < 2; i++) begin
            wr_reg(`ADDR_T0_RELOAD + 8'(2 * i), 8'h01);
            wr_reg(`ADDR_T0_PRE + 8'(2 * i), 8'h04);
            wr_reg(`ADDR_CTRL, i ? 8'h8C : 8'h43);
            repeat (20) @(posedge clk);
            check(pin_out === 1'b1, "timer out");
        end
    endtask
    task automatic t_casc;
        do_reset();
        wr_reg(`ADDR_CFG, 8'h01);
        wr_reg(`ADDR_T0_RELOAD, 8'h02);
        wr_reg(`ADDR_T0_PRE, 8'h06);
        wr_reg(`ADDR_T1_RELOAD, 8'h10);
        wr_reg(`ADDR_T1_PRE, 8'h04);
        wr_reg(`ADDR_CTRL, 8'h0F);
        repeat (40) @(posedge clk);
        rd_reg(`ADDR_T1_RELOAD, v);
        check(v > 8'h0A && v < 8'h0F, "cascade");
    endtask
    task automatic t_req;
        do_reset();
        ack(1'b0, vec);
        pin_partner_i.request(1'b0);
        repeat (6) @(posedge clk);
        rd_chk(`ADDR_IRQ, 8'h00, 8'h87);
        pin_partner_i.request(1'b1);
        wr_reg(`ADDR_CFG, 8'h02);
        pin_partner_i.request(1'b0);
        repeat (6) @(posedge clk);
        rd_chk(`ADDR_IRQ, 8'h01, 8'h87);
        wr_reg(`ADDR_MASK, 8'h81);
        ack(1'b1, vec);
        check(vec === `VEC_EXT, "external vector");
    endtask

    initial begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        int_ack = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        n_errors = 0;
        n_compared = 0;
        cyc = 0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        check(pin_oe_n === 1'b0 && int_request === 1'b0, "reset");
        rd_chk(8'h3C, 8'h00, 8'hFF);
        t_single();
        t_prio();
        t_cont();
        t_stop();
        t_ext();
        t_pin();
        t_casc();
        t_req();
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire
